// [aics_scheduler.sv]
// Analog input code scheduler: scaling, substitution codes and update timing
// Function
// - Voltage code is (input - 1 V) x 1024 rounded to nearest.
// - Current code is (input - 4 mA) x 256 rounded to nearest.
// - Elevated range adds 4096 to each valid code.
// - All channel registers refresh once per update interval, base 400 ms or 710 ms by variant.
// - Each deep out-of-range channel adds 220 ms to the update interval.
// - Under range counts toward the extension only at or below -3 V.
// - Shallow under range or sub-4 mA current raises the indication without extension.
// - Out-of-range channels read 0 (4095 elevated) under, 4096 (8192 elevated) over.
// - First three seconds after power-up and during failure recovery, all codes read 0.
// - The interval is recomputed each period, shrinking as channels return to range.
// - A range select chooses standard or elevated codes for all channels.
// - The latest code for each channel is held for the controller to poll.
// - Valid codes span 1..4095 standard and 4097..8191 elevated; others flag invalid data.
module aics_scheduler #(
	parameter int NCH = aics_pkg::NCH_SMALL,
	parameter int CYC_PER_MS = aics_pkg::MS_NS / aics_pkg::CLK_PERIOD_NS,
	parameter int POWERUP_MS = aics_pkg::POWERUP_MS
) (
	input wire logic clk, // 125 MHz clock
	input wire logic nrst, // Async reset, active low
	input wire aics_pkg::aics_sample_t [NCH-1:0] sample, // Converted samples per channel
	input wire logic elevRange, // 1 selects elevated range
	input wire logic failRecover, // High during failure recovery
	output aics_pkg::aics_code_t [NCH-1:0] chanCode, // Polled channel codes
	output logic underInd, // Some channel under range
	output logic overInd, // Over-range lamp drive
	output logic updStrobe // One cycle per register refresh
);
	import aics_pkg::*;

	localparam int BASE_MS = (NCH == NCH_SMALL) ? BASE4_MS : BASE8_MS;
	localparam int TW = $clog2(CYC_PER_MS + 1);
	localparam int OW = $clog2(NCH + 1);

	// Reset release synchroniser
	logic rstS1_r;
	logic rstN_r;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rstS1_r <= 1'b0;
			rstN_r <= 1'b0;
		end else begin
			rstS1_r <= 1'b1;
			rstN_r <= rstS1_r;
		end
	end

	// Scale one sample and decide its range
	function automatic aics_conv_t classify(input aics_sample_t s, input logic elev);
		logic signed [SMP_W-1:0] diff;
		logic signed [SMP_W-1:0] raw;
		aics_conv_t c;
		diff = '0;
		raw = '0;
		c = '0;
		if (s.isCurrent) begin
			// subtract 4 mA, scale 256, round
			diff = s.value - FOUR_MA;
			raw = (diff + I_HALF) >>> I_SHIFT;
		end else begin
			// subtract 1 V, scale 1024, round
			diff = s.value - ONE_V;
			raw = (diff + V_HALF) >>> V_SHIFT;
		end
		// zero or below and 4096 up are invalid
		c.under = (raw < RAW_MIN);
		c.over = (raw > RAW_MAX);
		// over range and, of under range, only deep voltage stretch the interval
		c.ext = c.over | (c.under & ~s.isCurrent & (s.value <= MINUS3_V));
		if (c.under) begin
			c.code = elev ? UNDER_ELEV : CODE_ZERO;
		end else if (c.over) begin
			c.code = elev ? OVER_ELEV : OVER_STD;
		end else begin
			// raw already bounded to 1..4095 here
			c.code = CODE_W'(raw[CODE_W-1:0]);
			// range select applies to every channel
			if (elev) begin
				c.code = c.code + ELEV_OFS;
			end
		end
		return c;
	endfunction

	aics_conv_t conv [NCH];

	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_conv
			assign conv[gi] = classify(sample[gi], elevRange);
		end
	endgenerate

	// Range summary of live samples
	logic [OW-1:0] oorCnt;
	logic [NCH-1:0] extVec;
	logic anyUnder;
	logic anyOver;
	logic [MS_W-1:0] intvCalc;

	always_comb begin
		oorCnt = '0;
		extVec = '0;
		anyUnder = 1'b0;
		anyOver = 1'b0;
		for (int i = 0; i < NCH; i++) begin
			oorCnt = oorCnt + OW'(conv[i].ext);
			extVec[i] = conv[i].ext;
			anyUnder = anyUnder | conv[i].under;
			// shallow under range also lights the over lamp
			anyOver = anyOver | conv[i].over | (conv[i].under & ~conv[i].ext);
		end
		// base plus one extension per deep out-of-range channel
		intvCalc = MS_W'(BASE_MS) + MS_W'(oorCnt) * MS_W'(EXT_MS);
	end

	// Scheduler state
	aics_state_t state_r;
	aics_state_t state_nxt;
	logic [TW-1:0] tick_r;
	logic [TW-1:0] tick_nxt;
	logic [MS_W-1:0] msCnt_r;
	logic [MS_W-1:0] msCnt_nxt;
	logic [MS_W-1:0] intv_r;
	logic [MS_W-1:0] intv_nxt;
	aics_code_t [NCH-1:0] chanCode_r;
	aics_code_t [NCH-1:0] chanCode_nxt;
	logic underInd_r;
	logic overInd_r;
	logic upd_r;
	logic upd_nxt;
	logic tickEnd;
	logic msEnd;
	logic [MS_W-1:0] limit;

	always_comb begin
		state_nxt = state_r;
		intv_nxt = intv_r;
		chanCode_nxt = chanCode_r;
		upd_nxt = 1'b0;
		tickEnd = (tick_r == TW'(CYC_PER_MS - 1));
		limit = (state_r == ST_POWERUP) ? MS_W'(POWERUP_MS) : intv_r;
		msEnd = tickEnd && (msCnt_r == limit - MS_W'(1));
		tick_nxt = tickEnd ? '0 : tick_r + TW'(1);
		msCnt_nxt = msEnd ? '0 : (tickEnd ? msCnt_r + MS_W'(1) : msCnt_r);
		case (state_r)
			ST_POWERUP: begin
				// zeros until the power-up hold ends
				chanCode_nxt = '0;
				if (msEnd) begin
					state_nxt = failRecover ? ST_RECOVER : ST_RUN;
					intv_nxt = intvCalc;
				end
			end
			ST_RUN: begin
				if (failRecover) begin
					state_nxt = ST_RECOVER;
					chanCode_nxt = '0;
					tick_nxt = '0;
					msCnt_nxt = '0;
				end else if (msEnd) begin
					// refresh all channels once per interval
					// latest codes held until next refresh
					for (int i = 0; i < NCH; i++) begin
						chanCode_nxt[i] = conv[i].code;
					end
					upd_nxt = 1'b1;
					// next interval follows the current range picture
					intv_nxt = intvCalc;
				end
			end
			ST_RECOVER: begin
				chanCode_nxt = '0;
				tick_nxt = '0;
				msCnt_nxt = '0;
				if (!failRecover) begin
					state_nxt = ST_RUN;
					intv_nxt = intvCalc;
				end
			end
			default: begin
				state_nxt = ST_POWERUP;
				chanCode_nxt = '0;
				tick_nxt = '0;
				msCnt_nxt = '0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstN_r) begin
		if (!rstN_r) begin
			state_r <= ST_POWERUP;
			tick_r <= '0;
			msCnt_r <= '0;
			intv_r <= MS_W'(BASE_MS);
			chanCode_r <= '0;
			underInd_r <= 1'b0;
			overInd_r <= 1'b0;
			upd_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			tick_r <= tick_nxt;
			msCnt_r <= msCnt_nxt;
			intv_r <= intv_nxt;
			chanCode_r <= chanCode_nxt;
			underInd_r <= anyUnder;
			overInd_r <= anyOver;
			upd_r <= upd_nxt;
		end
	end

	assign chanCode = chanCode_r;
	assign underInd = underInd_r;
	assign overInd = overInd_r;
	assign updStrobe = upd_r;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstN_r);

	a_powerup_zero: assert property (
		state_r == ST_POWERUP |-> chanCode_r == '0
	) else $error("codes not zero during power-up hold");

	a_recover_zero: assert property (
		failRecover && state_r != ST_POWERUP |=> chanCode_r == '0 && !upd_r
	) else $error("codes not zero during recovery");

	a_interval_len: assert property (
		upd_r |-> intv_r == MS_W'(BASE_MS) +
			MS_W'($past($countones(extVec))) * MS_W'(EXT_MS)
	) else $error("update interval does not match out-of-range count");

	a_hold_codes: assert property (
		state_r == ST_RUN && $past(state_r) == ST_RUN && !upd_r |-> $stable(chanCode_r)
	) else $error("codes changed between refreshes");

	a_first_refresh: assert property (
		$rose(state_r == ST_RUN) && !$past(upd_r) |-> !upd_r [*2]
	) else $error("refresh too early after entering run");

	a_strobe_pulse: assert property (
		upd_r |=> !upd_r
	) else $error("refresh strobe longer than one cycle");

	a_strobe_run: assert property (
		upd_r |-> state_r == ST_RUN && $past(state_r) == ST_RUN
	) else $error("refresh outside run state");

	a_recover_quiet: assert property (
		state_r == ST_RECOVER |-> chanCode_r == '0 && !upd_r
	) else $error("codes or strobe active during recovery");

	a_interval_span: assert property (
		state_r != ST_POWERUP |-> intv_r >= MS_W'(BASE_MS) &&
			intv_r <= MS_W'(BASE_MS + NCH * EXT_MS)
	) else $error("update interval outside its span");

	generate
		for (gi = 0; gi < NCH; gi++) begin : g_chk
			a_span_std: assert property (
				upd_r && !$past(elevRange) |-> chanCode_r[gi] <= OVER_STD
			) else $error("standard code outside span");

			a_span_elev: assert property (
				upd_r && $past(elevRange) |->
					chanCode_r[gi] >= UNDER_ELEV && chanCode_r[gi] <= OVER_ELEV
			) else $error("elevated code outside span");

			a_under_code: assert property (
				upd_r && $past(conv[gi].under) |->
					chanCode_r[gi] == ($past(elevRange) ? UNDER_ELEV : CODE_ZERO)
			) else $error("wrong under-range code");

			a_over_code: assert property (
				upd_r && $past(conv[gi].over) |->
					chanCode_r[gi] == ($past(elevRange) ? OVER_ELEV : OVER_STD)
			) else $error("wrong over-range code");

			a_elev_offset: assert property (
				upd_r && $past(elevRange && !conv[gi].under && !conv[gi].over) |->
					chanCode_r[gi] > UNDER_ELEV && chanCode_r[gi] < OVER_ELEV
			) else $error("elevated valid code lacks offset");

			a_shallow_ind: assert property (
				rstN_r && conv[gi].under && !conv[gi].ext |=> overInd_r && underInd_r
			) else $error("shallow under range not indicated");

			a_valid_std: assert property (
				upd_r && $past(!elevRange && !conv[gi].under && !conv[gi].over) |->
					chanCode_r[gi] != CODE_ZERO && chanCode_r[gi] < OVER_STD
			) else $error("standard valid code outside span");

			a_under_ind: assert property (
				rstN_r && conv[gi].under |=> underInd_r
			) else $error("under range not indicated");
		end
	endgenerate
endmodule

// [aics_pkg.sv]
// Constants and types shared by the analog input code scheduler
package aics_pkg;
	// Sample format: signed fixed point, FRAC fractional bits (volts or milliamps)
	localparam int FRAC = 12;
	localparam int SMP_W = 20;
	localparam int CODE_W = 14;
	localparam int MS_W = 12;
	// Clock and time units
	localparam int CLK_PERIOD_NS = 8;
	localparam int MS_NS = 1000000;
	localparam int POWERUP_MS = 3000;
	localparam int BASE4_MS = 400;
	localparam int BASE8_MS = 710;
	localparam int EXT_MS = 220;
	localparam int NCH_SMALL = 4;
	// Scaling: volts x1024, milliamps x256
	localparam int V_SHIFT = FRAC - 10;
	localparam int I_SHIFT = FRAC - 8;
	localparam logic signed [SMP_W-1:0] V_HALF = 20'sh00002;
	localparam logic signed [SMP_W-1:0] I_HALF = 20'sh00008;
	localparam logic signed [SMP_W-1:0] ONE_V = 20'sh01000;
	localparam logic signed [SMP_W-1:0] FOUR_MA = 20'sh04000;
	localparam logic signed [SMP_W-1:0] MINUS3_V = 20'shfd000;
	localparam logic signed [SMP_W-1:0] RAW_MIN = 20'sh00001;
	localparam logic signed [SMP_W-1:0] RAW_MAX = 20'sh00fff;
	// Data codes
	localparam logic [CODE_W-1:0] CODE_ZERO = 14'h0000;
	localparam logic [CODE_W-1:0] UNDER_ELEV = 14'h0fff;
	localparam logic [CODE_W-1:0] OVER_STD = 14'h1000;
	localparam logic [CODE_W-1:0] ELEV_OFS = 14'h1000;
	localparam logic [CODE_W-1:0] OVER_ELEV = 14'h2000;

	typedef logic [CODE_W-1:0] aics_code_t;

	typedef struct packed {
		logic isCurrent;
		logic signed [SMP_W-1:0] value;
	} aics_sample_t;

	typedef struct packed {
		aics_code_t code;
		logic under;
		logic over;
		logic ext;
	} aics_conv_t;

	typedef enum logic [1:0] {
		ST_POWERUP = 2'b00,
		ST_RUN = 2'b01,
		ST_RECOVER = 2'b10
	} aics_state_t;
endpackage

// [aics_poller.sv]
// Controller model that polls channel codes into its input registers
module aics_poller #(
	parameter int NCH = 4,
	parameter int POLL = 3
) (
	input wire logic clk, // Clock
	input wire logic nrst, // Async reset, active low
	input wire aics_pkg::aics_code_t [NCH-1:0] chanCode, // Module codes
	output aics_pkg::aics_code_t [NCH-1:0] inReg // Polled input registers
);
	timeunit 1ns;
	timeprecision 1ps;
	import aics_pkg::*;
	int cnt_r;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= 0;
			inReg <= '0;
		end else begin
			cnt_r <= (cnt_r == POLL - 1) ? 0 : cnt_r + 1;
			if (cnt_r == 0) begin
				inReg <= chanCode;
			end
		end
	end
endmodule

// [aics_scheduler_tb.sv]
// Self-checking bench for the analog input code scheduler
module aics_scheduler_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import aics_pkg::*;
	localparam int CPM = 2;
	localparam int PUP = 2;
	localparam int BASE = BASE4_MS * CPM;
	localparam int EXT = EXT_MS * CPM;
	localparam int HOLD = PUP * CPM;
	// Short timing keeps the whole run near 19k cycles
	localparam int LIMIT = 40000;
	localparam aics_sample_t [3:0] SA = {1'b0, 20'h01004, 1'b0, 20'h04ffc, 1'b1, 20'h0c008,
		1'b0, 20'h03002};
	localparam aics_sample_t [3:0] SB = {1'b0, 20'h01000, 1'b1, 20'h02000, 1'b0, 20'hfd000,
		1'b0, 20'h04ffe};
	localparam aics_sample_t [3:0] SC = {1'b0, 20'h01000, 1'b1, 20'h02000, 1'b0, 20'h03000,
		1'b0, 20'h04ffe};
	localparam aics_sample_t [3:0] SD = {1'b0, 20'h01000, 1'b1, 20'h02000, 1'b0, 20'h03000,
		1'b0, 20'h03002};
	logic clk, nrst, elevRange, failRecover, underInd, overInd, updStrobe;
	aics_sample_t [3:0] sample;
	aics_code_t [3:0] chanCode, inReg;
	int errors = 0, comparisons = 0, cycles = 0;

	aics_scheduler #(.NCH(4), .CYC_PER_MS(CPM), .POWERUP_MS(PUP)) uut (.clk(clk), .nrst(nrst),
		.sample(sample), .elevRange(elevRange), .failRecover(failRecover), .chanCode(chanCode),
		.underInd(underInd), .overInd(overInd), .updStrobe(updStrobe));
	aics_poller #(.NCH(4), .POLL(3)) ctl (.clk(clk), .nrst(nrst), .chanCode(chanCode),
		.inReg(inReg));

	task automatic chk_code(aics_code_t g, aics_code_t e);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("ERROR %0t code got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_bit(logic g, logic e);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("ERROR %0t flag got %b exp %b", $time, g, e);
		end
	endtask
	task automatic chk_cnt(int g, int e);
		comparisons++;
		if (g != e) begin
			errors++;
			$display("ERROR %0t interval got %0d exp %0d", $time, g, e);
		end
	endtask
	task automatic give_verdict();
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Bounded by the global cycle ceiling
	task automatic wait_strobe(output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (updStrobe !== 1'b1);
	endtask
	task automatic t_powerup();
		int n;
		wait_strobe(n);
		chk_bit(n >= HOLD + BASE && n <= HOLD + BASE + 4, 1'b1);
	endtask
	// Called just after a refresh; codes land at the next one
	task automatic codes(aics_sample_t [3:0] s, logic el, aics_code_t [3:0] e);
		int n;
		sample = s;
		elevRange = el;
		wait_strobe(n);
		repeat (4) @(negedge clk);
		for (int i = 0; i < 4; i++) begin
			chk_code(inReg[i], e[i]);
		end
	endtask
	task automatic intv(aics_sample_t [3:0] s, int e, logic ov, logic ud);
		int n;
		sample = s;
		wait_strobe(n);
		chk_bit(overInd, ov);
		chk_bit(underInd, ud);
		wait_strobe(n);
		chk_cnt(n, e);
	endtask
	task automatic t_recover();
		int n;
		logic seen;
		seen = 1'b0;
		failRecover = 1'b1;
		@(negedge clk);
		for (int i = 0; i < 4; i++) begin
			chk_code(chanCode[i], CODE_ZERO);
		end
		repeat (BASE + 100) begin
			@(negedge clk);
			seen = seen | updStrobe;
		end
		chk_bit(seen, 1'b0);
		failRecover = 1'b0;
		wait_strobe(n);
		chk_bit(n >= BASE && n <= BASE + 2, 1'b1);
	endtask
	// Second reset mid-run, recovery held through the power-up hold
	task automatic t_reset();
		int n;
		logic seen;
		seen = 1'b0;
		sample = SB;
		failRecover = 1'b1;
		nrst = 1'b0;
		@(negedge clk);
		for (int i = 0; i < 4; i++) begin
			chk_code(chanCode[i], CODE_ZERO);
		end
		chk_bit(underInd, 1'b0);
		chk_bit(overInd, 1'b0);
		nrst = 1'b1;
		repeat (HOLD + BASE) begin
			@(negedge clk);
			seen = seen | updStrobe;
		end
		chk_bit(seen, 1'b0);
		chk_code(chanCode[0], CODE_ZERO);
		failRecover = 1'b0;
		wait_strobe(n);
		chk_bit(n >= BASE + 2 * EXT && n <= BASE + 2 * EXT + 2, 1'b1);
	endtask

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			errors++;
			give_verdict();
		end
	end
	initial begin
		nrst = 1'b0;
		elevRange = 1'b0;
		failRecover = 1'b0;
		sample = SA;
		repeat (6) @(negedge clk);
		nrst = 1'b1;
		t_powerup();
		codes(SA, 1'b0, {14'h0001, 14'h0fff, 14'h0801, 14'h0801});
		codes(SA, 1'b1, {14'h1001, 14'h1fff, 14'h1801, 14'h1801});
		codes(SB, 1'b0, {14'h0000, 14'h0000, 14'h0000, 14'h1000});
		codes(SB, 1'b1, {14'h0fff, 14'h0fff, 14'h0fff, 14'h2000});
		intv(SB, BASE + 2 * EXT, 1'b1, 1'b1);
		intv(SC, BASE + EXT, 1'b1, 1'b1);
		intv(SD, BASE, 1'b1, 1'b1);
		intv(SA, BASE, 1'b0, 1'b0);
		t_recover();
		t_reset();
		give_verdict();
	end
endmodule
